// >>> common/fault_det_pkg.sv
// Constants, types and register map of the arithmetic fault detector
package fault_det_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int ID_W = 4;
   localparam int CNT_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] OFS_FAULT_CNT = 8'h14;

   // CTRL fields
   localparam int CTRL_ACT_BIT = 0;
   localparam int CTRL_WIPE_BIT = 1;
   localparam int CTRL_CNT_CLR_BIT = 2;

   // CFG fields
   localparam int CFG_SEL_LSB = 0;
   localparam int CFG_SELF_CLEAR_BIT = 4;
   localparam int CFG_ID_LSB = 8;

   // STATUS fields
   localparam int STAT_FLAG_BIT = 0;
   localparam int STAT_ARMED_BIT = 1;
   localparam int STAT_DIV_BIT = 2;
   localparam int STAT_OVF_BIT = 3;

   // Interrupt status and mask fields
   localparam int IRQ_W = 3;
   localparam int IRQ_FLAG_SET_BIT = 0;
   localparam int IRQ_DIV_BIT = 1;
   localparam int IRQ_OVF_BIT = 2;

   localparam logic [ID_W-1:0] ID_NULL = 4'h0;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

   typedef enum logic [2:0] {
      SEL_DIV = 3'b001,
      SEL_OVF = 3'b010,
      SEL_ANY = 3'b100
   } fault_sel_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ARMED = 2'b10
   } det_state_t;

   typedef struct packed {
      logic div_zero_flag;
      logic overflow_flag;
   } fault_bits_t;

   typedef struct packed {
      logic [ID_W-1:0] source_block_id;
      logic self_clear_mode;
      logic [2:0] sel;
   } det_cfg_t;

   localparam logic [2:0] SEL_RESET = 3'b100;

endpackage

// >>> rtl/arith_fault_detector.sv
// Arithmetic fault detector with register port and interrupt
`timescale 1ns/1ps
module arith_fault_detector #(
   parameter int NUM_SRC = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [fault_det_pkg::ADDR_W-1:0] addr_i,
   input wire logic [fault_det_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [fault_det_pkg::DATA_W-1:0] rdata_o,
   input wire logic scan_exec_i,
   input wire logic [NUM_SRC-1:0] src_eval_i,
   input wire fault_det_pkg::fault_bits_t src_faults_i [NUM_SRC],
   output logic flag_o,
   output logic irq_o
);
   import fault_det_pkg::*;

   logic act;
   logic act_q;
   logic wipe;
   det_cfg_t cfg;
   det_state_t state;
   fault_bits_t snap [NUM_SRC];
   fault_bits_t cur_bits;
   logic id_valid;
   logic fault_now;
   logic eval;
   logic next_flag;
   logic [CNT_W-1:0] fault_cnt;
   logic cnt_clr;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic irq_clr;
   logic mask_we;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Control register: activation and wipe are levels
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act <= 1'b0;
         wipe <= 1'b0;
      end else if (wr_i && hit(addr_i, OFS_CTRL)) begin
         act <= wdata_i[CTRL_ACT_BIT];
         wipe <= wdata_i[CTRL_WIPE_BIT];
      end
   end

   assign cnt_clr = wr_i && hit(addr_i, OFS_CTRL) && wdata_i[CTRL_CNT_CLR_BIT];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg.sel <= SEL_RESET;
         cfg.self_clear_mode <= 1'b0;
         cfg.source_block_id <= ID_NULL;
      end else if (wr_i && hit(addr_i, OFS_CFG)) begin
         cfg.sel <= wdata_i[CFG_SEL_LSB +: 3];
         cfg.self_clear_mode <= wdata_i[CFG_SELF_CLEAR_BIT];
         cfg.source_block_id <= wdata_i[CFG_ID_LSB +: ID_W];
      end
   end

   // Activation: only a 0 to 1 transition arms; dropping disarms
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_q <= 1'b0;
      end else begin
         act_q <= act;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (act && !act_q) begin
                  state <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (!act) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Source fault bits held from each source's last evaluation
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < NUM_SRC; k++) begin
            snap[k] <= '0;
         end
      end else begin
         for (int k = 0; k < NUM_SRC; k++) begin
            if (src_eval_i[k]) begin
               snap[k] <= src_faults_i[k];
            end
         end
      end
   end

   fault_select #(
      .NUM_SRC(NUM_SRC)
   ) u_sel (
      .snap_i(snap),
      .live_i(src_faults_i),
      .src_eval_i(src_eval_i),
      .cfg_i(cfg),
      .id_valid_o(id_valid),
      .bits_o(cur_bits),
      .fault_o(fault_now)
   );

   assign eval = scan_exec_i && (state == ST_ARMED);

   // Wipe and null reference dominate any evaluation
   always_comb begin
      next_flag = flag_o;
      if (eval) begin
         if (cfg.self_clear_mode) begin
            next_flag = fault_now;
         end else begin
            next_flag = flag_o | fault_now;
         end
      end
      if (wipe || !id_valid) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_o <= 1'b0;
      end else begin
         flag_o <= next_flag;
      end
   end

   // Saturating count of evaluations that found the selected fault
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_cnt <= '0;
      end else if (cnt_clr) begin
         fault_cnt <= '0;
      end else if (eval && fault_now && fault_cnt != CNT_MAX) begin
         fault_cnt <= fault_cnt + 1'b1;
      end
   end

   assign irq_event[IRQ_FLAG_SET_BIT] = next_flag && !flag_o;
   assign irq_event[IRQ_DIV_BIT] = eval && cur_bits.div_zero_flag;
   assign irq_event[IRQ_OVF_BIT] = eval && cur_bits.overflow_flag;
   assign irq_clr = rd_i && hit(addr_i, OFS_IRQ_STAT);
   assign mask_we = wr_i && hit(addr_i, OFS_IRQ_MASK);

   fault_irq #(
      .W(IRQ_W)
   ) u_irq (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .event_i(irq_event),
      .clr_i(irq_clr),
      .mask_we_i(mask_we),
      .mask_wdata_i(wdata_i[IRQ_W-1:0]),
      .stat_o(irq_stat),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= '0;
         if (rd_i) begin
            unique case (addr_i)
               OFS_CTRL: begin
                  rdata_o[CTRL_ACT_BIT] <= act;
                  rdata_o[CTRL_WIPE_BIT] <= wipe;
               end
               OFS_CFG: begin
                  rdata_o[CFG_SEL_LSB +: 3] <= cfg.sel;
                  rdata_o[CFG_SELF_CLEAR_BIT] <= cfg.self_clear_mode;
                  rdata_o[CFG_ID_LSB +: ID_W] <= cfg.source_block_id;
               end
               OFS_STATUS: begin
                  rdata_o[STAT_FLAG_BIT] <= flag_o;
                  rdata_o[STAT_ARMED_BIT] <= state == ST_ARMED;
                  rdata_o[STAT_DIV_BIT] <= cur_bits.div_zero_flag;
                  rdata_o[STAT_OVF_BIT] <= cur_bits.overflow_flag;
               end
               OFS_IRQ_STAT: rdata_o[IRQ_W-1:0] <= irq_stat;
               OFS_IRQ_MASK: rdata_o[IRQ_W-1:0] <= irq_mask;
               OFS_FAULT_CNT: rdata_o[CNT_W-1:0] <= fault_cnt;
               default: rdata_o <= '0;
            endcase
         end
      end
   end

   property p_wipe_low;
      @(posedge mclk_i) disable iff (!rst_n_i)
      wipe |=> !flag_o;
   endproperty
   a_wipe_low: assert property (p_wipe_low)
      else $error("flag not low after wipe");

   property p_wipe_beats_fault;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (wipe && eval && fault_now) |=> !flag_o;
   endproperty
   a_wipe_beats_fault: assert property (p_wipe_beats_fault)
      else $error("fault beat wipe");

   property p_null_low;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (cfg.source_block_id == ID_NULL) |=> !flag_o;
   endproperty
   a_null_low: assert property (p_null_low)
      else $error("flag high with null source");

   property p_self_clear;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (eval && cfg.self_clear_mode && id_valid && !wipe)
         |=> flag_o == $past(fault_now);
   endproperty
   a_self_clear: assert property (p_self_clear)
      else $error("self-clear flag wrong");

   property p_hold;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (flag_o && !cfg.self_clear_mode && id_valid && !wipe) |=> flag_o;
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag dropped without wipe");

   property p_arm_first;
      @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(flag_o) |-> $past(scan_exec_i) && $past(state == ST_ARMED);
   endproperty
   a_arm_first: assert property (p_arm_first)
      else $error("flag set without armed evaluation");

   property p_same_scan;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (eval && id_valid && !wipe && fault_now) |=> flag_o;
   endproperty
   a_same_scan: assert property (p_same_scan)
      else $error("fault not reflected");

   property p_any_sel;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (eval && id_valid && cfg.sel == SEL_ANY && !wipe
         && (cur_bits.div_zero_flag || cur_bits.overflow_flag))
         |=> flag_o;
   endproperty
   a_any_sel: assert property (p_any_sel)
      else $error("combined select missed fault");

   property p_ovf_ignores_div;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (eval && cfg.sel == SEL_OVF && cfg.self_clear_mode
         && !cur_bits.overflow_flag) |=> !flag_o;
   endproperty
   a_ovf_ignores_div: assert property (p_ovf_ignores_div)
      else $error("overflow select took divide bit");

   property p_later_source;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (src_eval_i[0] && !scan_exec_i) |=> snap[0] == $past(src_faults_i[0]);
   endproperty
   a_later_source: assert property (p_later_source)
      else $error("source bits not held for next scan");

endmodule

// >>> rtl/fault_irq.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ps
module fault_irq #(
   parameter int W = 3
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] event_i,
   input wire logic clr_i,
   input wire logic mask_we_i,
   input wire logic [W-1:0] mask_wdata_i,
   output logic [W-1:0] stat_o,
   output logic [W-1:0] mask_o,
   output logic irq_o
);

   // Set wins over clear-on-read so no event is lost
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_o <= '0;
      end else if (clr_i) begin
         stat_o <= event_i;
      end else begin
         stat_o <= stat_o | event_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_o <= '0;
      end else if (mask_we_i) begin
         mask_o <= mask_wdata_i;
      end
   end

   assign irq_o = |(stat_o & mask_o);

   property p_irq_sticky;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (|event_i) |=> ((stat_o & $past(event_i)) == $past(event_i));
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("interrupt event not captured");

endmodule

// >>> rtl/fault_select.sv
// Source selection and fault type selection
`timescale 1ns/1ps
module fault_select #(
   parameter int NUM_SRC = 4
) (
   input wire fault_det_pkg::fault_bits_t snap_i [NUM_SRC],
   input wire fault_det_pkg::fault_bits_t live_i [NUM_SRC],
   input wire logic [NUM_SRC-1:0] src_eval_i,
   input wire fault_det_pkg::det_cfg_t cfg_i,
   output logic id_valid_o,
   output fault_det_pkg::fault_bits_t bits_o,
   output logic fault_o
);
   import fault_det_pkg::*;

   // Null or out-of-range identifiers reference nothing
   function automatic logic id_ok(input logic [ID_W-1:0] id);
      return (id != ID_NULL) && (int'(id) <= NUM_SRC);
   endfunction

   always_comb begin
      id_valid_o = id_ok(cfg_i.source_block_id);
      bits_o = '0;
      for (int k = 0; k < NUM_SRC; k++) begin
         if (id_valid_o && (int'(cfg_i.source_block_id) == k + 1)) begin
            // Same-cycle evaluation counts as earlier in the scan
            bits_o = src_eval_i[k] ? live_i[k] : snap_i[k];
         end
      end
   end

   always_comb begin
      fault_o = 1'b0;
      unique case (cfg_i.sel)
         SEL_DIV: fault_o = bits_o.div_zero_flag;
         SEL_OVF: fault_o = bits_o.overflow_flag;
         SEL_ANY: fault_o = bits_o.div_zero_flag | bits_o.overflow_flag;
         default: fault_o = 1'b0;
      endcase
      if (!id_valid_o) begin
         fault_o = 1'b0;
      end
   end

endmodule

// >>> sim/arith_src_model.sv
// Model of the arithmetic blocks that feed the fault detector
`timescale 1ns/1ps
module arith_src_model #(
   parameter int NUM_SRC = 4
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_SRC-1:0] run_i,
   input wire fault_det_pkg::fault_bits_t res_i,
   output logic [NUM_SRC-1:0] src_eval_o,
   output fault_det_pkg::fault_bits_t src_faults_o [NUM_SRC]
);
   import fault_det_pkg::*;

   fault_bits_t last [NUM_SRC];

   // Evaluation finishes in the cycle it is commanded
   assign src_eval_o = run_i;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < NUM_SRC; k++) begin
            last[k] <= '0;
         end
      end else begin
         for (int k = 0; k < NUM_SRC; k++) begin
            if (run_i[k]) begin
               last[k] <= res_i;
            end
         end
      end
   end

   // Bits valid only with the eval pulse; otherwise junk, not a held value
   always_comb begin
      for (int k = 0; k < NUM_SRC; k++) begin
         src_faults_o[k] = run_i[k] ? res_i : ~last[k];
      end
   end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the arithmetic fault detector
`timescale 1ns/1ps
module tb;
   import fault_det_pkg::*;

   localparam int NUM_SRC = 4;

   logic mclk_i;
   logic rst_n_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [DATA_W-1:0] rdata_o;
   logic scan_exec_i;
   logic [NUM_SRC-1:0] src_eval_i;
   fault_bits_t src_faults_i [NUM_SRC];
   logic flag_o;
   logic irq_o;
   logic [NUM_SRC-1:0] run;
   fault_bits_t res;
   int fail_count;
   int checks_done;
   logic [31:0] d;
   logic [2:0] sels [3];

   arith_fault_detector #(.NUM_SRC(NUM_SRC)) arith_fault_detector_i (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .scan_exec_i(scan_exec_i),
      .src_eval_i(src_eval_i),
      .src_faults_i(src_faults_i),
      .flag_o(flag_o),
      .irq_o(irq_o)
   );

   arith_src_model #(.NUM_SRC(NUM_SRC)) arith_src_model_i (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .run_i(run),
      .res_i(res),
      .src_eval_o(src_eval_i),
      .src_faults_o(src_faults_i)
   );

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   task automatic end_sim();
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string m);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h want %h", $time, m, seen,
                  exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   // One cycle of source evaluation and/or detector slot, then settle
   task automatic step(input logic [NUM_SRC-1:0] m, input fault_bits_t b,
                       input logic ex);
      @(posedge mclk_i);
      run <= m;
      res <= b;
      scan_exec_i <= ex;
      @(posedge mclk_i);
      run <= '0;
      scan_exec_i <= 1'b0;
      #1;
   endtask

   function automatic logic [31:0] cfg(input logic [3:0] id,
                                       input logic sc, input logic [2:0] s);
      cfg = {20'h00000, id, 3'h0, sc, 1'b0, s};
   endfunction

   function automatic logic want(input logic [2:0] s, input fault_bits_t b);
      case (s)
         3'b001: want = b.div_zero_flag;
         3'b010: want = b.overflow_flag;
         default: want = b.div_zero_flag | b.overflow_flag;
      endcase
   endfunction

   // Watchdog: a hang counts as a failure
   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      end_sim();
   end

   initial begin
      sels = '{3'b001, 3'b010, 3'b100};
      fail_count = 0;
      checks_done = 0;
      rst_n_i = 1'b0;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      scan_exec_i = 1'b0;
      run = '0;
      res = '0;
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      chk(flag_o, 1'b0, "flag after reset");
      chk(irq_o, 1'b0, "irq after reset");
      rd(OFS_CFG, d);
      chk(d, 32'h0000_0004, "cfg reset");
      rd(8'h18, d);
      chk(d, 32'h0000_0000, "unmapped read");
      // Not yet armed: slot ignored
      wr(OFS_CFG, cfg(4'h1, 1'b1, 3'b100));
      step(4'h1, 2'b11, 1'b1);
      chk(flag_o, 1'b0, "unarmed");
      wr(OFS_CTRL, 32'h0000_0001);
      step(4'h1, 2'b11, 1'b1);
      chk(flag_o, 1'b1, "armed");
      // Null and out-of-range source, sticky mode so a leak would show
      wr(OFS_CFG, cfg(4'h0, 1'b0, 3'b100));
      step(4'hF, 2'b11, 1'b1);
      chk(flag_o, 1'b0, "null id");
      wr(OFS_CFG, cfg(4'h5, 1'b0, 3'b100));
      step(4'hF, 2'b11, 1'b1);
      chk(flag_o, 1'b0, "id out of range");
      // Every selection against every fault pair, source 2 only
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CFG, cfg(4'h2, 1'b1, sels[i]));
         rd(OFS_CFG, d);
         chk(d, cfg(4'h2, 1'b1, sels[i]), "cfg readback");
         for (int f = 0; f < 4; f++) begin
            step(4'h2, f[1:0], 1'b1);
            chk(flag_o, want(sels[i], f[1:0]), "select");
         end
      end
      // Source evaluated after the slot is seen one scan later
      wr(OFS_CFG, cfg(4'h2, 1'b1, 3'b100));
      step(4'h2, 2'b00, 1'b1);
      chk(flag_o, 1'b0, "clean eval");
      step(4'h0, 2'b00, 1'b1);
      step(4'h3, 2'b10, 1'b0);
      chk(flag_o, 1'b0, "late eval not yet seen");
      step(4'h0, 2'b00, 1'b1);
      chk(flag_o, 1'b1, "late eval next scan");
      // Sticky mode, wipe, and wipe against a new fault
      step(4'h2, 2'b00, 1'b1);
      chk(flag_o, 1'b0, "clear before sticky");
      wr(OFS_CFG, cfg(4'h2, 1'b0, 3'b100));
      step(4'h2, 2'b01, 1'b1);
      chk(flag_o, 1'b1, "sticky set");
      step(4'h2, 2'b00, 1'b1);
      chk(flag_o, 1'b1, "sticky holds");
      wr(OFS_CTRL, 32'h0000_0003);
      @(posedge mclk_i);
      #1;
      chk(flag_o, 1'b0, "wipe");
      step(4'h2, 2'b10, 1'b1);
      chk(flag_o, 1'b0, "wipe beats fault");
      wr(OFS_CTRL, 32'h0000_0001);
      @(posedge mclk_i);
      #1;
      chk(flag_o, 1'b0, "wipe released");
      // Interrupt: masked, unmasked, cleared by read
      rd(OFS_IRQ_STAT, d);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      step(4'h2, 2'b11, 1'b1);
      chk(flag_o, 1'b1, "flag for irq");
      chk(irq_o, 1'b0, "irq masked");
      wr(OFS_IRQ_MASK, 32'h0000_0007);
      @(posedge mclk_i);
      #1;
      chk(irq_o, 1'b1, "irq unmasked");
      rd(OFS_IRQ_MASK, d);
      chk(d, 32'h0000_0007, "mask readback");
      rd(OFS_IRQ_STAT, d);
      chk(d, 32'h0000_0007, "irq status");
      chk(irq_o, 1'b0, "irq after clear");
      rd(OFS_IRQ_STAT, d);
      chk(d, 32'h0000_0000, "irq status cleared");
      // Status and fault count, then the count clear
      rd(OFS_STATUS, d);
      chk(d, 32'h0000_000F, "status");
      rd(OFS_FAULT_CNT, d);
      chk(d, 32'h0000_000C, "fault count");
      wr(OFS_CTRL, 32'h0000_0005);
      rd(OFS_FAULT_CNT, d);
      chk(d, 32'h0000_0000, "fault count cleared");
      // Dropping activation disarms; only a fresh rising edge re-arms
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_CFG, cfg(4'h2, 1'b1, 3'b100));
      step(4'h2, 2'b00, 1'b1);
      chk(flag_o, 1'b1, "disarmed slot ignored");
      rd(OFS_STATUS, d);
      chk(d, 32'h0000_0001, "status disarmed");
      wr(OFS_CTRL, 32'h0000_0001);
      step(4'h1, 2'b11, 1'b1);
      chk(flag_o, 1'b0, "other source ignored");
      step(4'h2, 2'b11, 1'b1);
      chk(flag_o, 1'b1, "fault before bad select");
      wr(OFS_CFG, cfg(4'h2, 1'b1, 3'b000));
      step(4'h2, 2'b11, 1'b1);
      chk(flag_o, 1'b0, "undefined select");
      rd(OFS_FAULT_CNT, d);
      chk(d, 32'h0000_0001, "count after clear");
      end_sim();
   end
endmodule
